// *** core/ics_pkg.sv ***
package ics_pkg;
	// ----------------------------------------------------------------
	// instruction-cycle timing
	// ----------------------------------------------------------------
	localparam int PHASES = 4; // system clocks in one instruction cycle
	localparam int PHASE_W = 2; // width of the phase count
	localparam logic [PHASE_W-1:0] PHASE_FIRST = 2'h0; // phase that opens a cycle
	localparam logic [PHASE_W-1:0] PHASE_LAST = PHASE_W'(PHASES - 1); // boundary phase
	localparam logic [PHASE_W-1:0] PHASE_STEP = 2'h1; // phase advance per clock

	// ----------------------------------------------------------------
	// instruction word fields
	// ----------------------------------------------------------------
	localparam int OP_HI = 15; // opcode field
	localparam int OP_LO = 11;
	localparam int BIT_HI = 10; // bit index for single-bit ops
	localparam int BIT_LO = 8;
	localparam int OPND_HI = 7; // data address or immediate
	localparam int TGT_HI = 10; // jump and call target
	localparam int TBL_HI_LO = 8; // low bit of the table word high byte

	// ----------------------------------------------------------------
	// address map
	// ----------------------------------------------------------------
	localparam int PC_W = 11; // program counter width
	localparam int DADDR_W = 9; // data address width
	localparam logic [DADDR_W-9:0] SECTOR0 = 1'h0; // plain access reaches sector 0 only
	localparam logic [7:0] PCL_ADDR = 8'h07; // data address of program_counter_low
	localparam logic [PC_W-9:0] TABLE_PAGE = 3'h7; // program memory page holding tables
	localparam logic [PC_W-1:0] PC_STEP = 11'h001; // next instruction
	localparam logic [PC_W-1:0] SKIP_STEP = 11'h002; // bypass one instruction
	localparam int BYTE_MAX = 255; // largest unsigned byte

	// ----------------------------------------------------------------
	// internal_rc_oscillator frequency codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RC_8MHZ = 2'h0;
	localparam logic [1:0] RC_12MHZ = 2'h1;
	localparam logic [1:0] RC_16MHZ = 2'h2;
	localparam logic [1:0] RC_BAD = 2'h3; // unprogrammed code, falls back to 8 MHz

	// ----------------------------------------------------------------
	// operations and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		nop_op = 5'b00000, move_mem_to_acc_op = 5'b00001, move_acc_to_mem_op = 5'b00010,
		move_imm_to_acc_op = 5'b00011, add_mem_op = 5'b00100, add_imm_op = 5'b00101,
		sub_mem_op = 5'b00110, sub_imm_op = 5'b00111, and_mem_op = 5'b01000,
		or_mem_op = 5'b01001, xor_mem_op = 5'b01010, complement_op = 5'b01011,
		increment_op = 5'b01100, increment_to_acc_op = 5'b01101, decrement_op = 5'b01110,
		decrement_to_acc_op = 5'b01111, rotate_right_op = 5'b10000, rotate_left_op = 5'b10001,
		rotate_right_carry_op = 5'b10010, rotate_left_carry_op = 5'b10011,
		bit_set_op = 5'b10100, bit_clear_op = 5'b10101, unconditional_jump_op = 5'b10110,
		subroutine_call_op = 5'b10111, subroutine_return_op = 5'b11000,
		interrupt_return_op = 5'b11001, skip_if_zero_op = 5'b11010,
		skip_if_bit_set_op = 5'b11011, table_read_op = 5'b11100
	} ics_op_t;

	typedef enum logic [0:0] {
		seq_exec = 1'b0, // executing a fresh instruction
		seq_extra = 1'b1 // second instruction cycle of a two-cycle op
	} ics_seq_t;

	// immediate forms take their operand from the word, not data memory
	function automatic logic is_imm(input ics_op_t op);
		is_imm = (op == move_imm_to_acc_op) || (op == add_imm_op) || (op == sub_imm_op);
	endfunction : is_imm
endpackage : ics_pkg

// *** core/ics_core_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface ics_core_if;
	logic [ics_pkg::PHASE_W-1:0] phase; // phase within the instruction cycle
	logic cycle_end; // last phase of the cycle
	ics_pkg::ics_op_t op; // operation to evaluate
	logic [7:0] acc; // accumulator value
	logic [7:0] mem; // data byte or immediate
	logic [2:0] bit_idx; // bit for single-bit ops
	logic carry_in; // current carry flag
	logic [7:0] result; // computed byte
	logic carry_out; // new carry
	logic zero; // result is zero
	logic to_mem; // result goes back to data memory
	logic to_acc; // result goes to the accumulator
	logic set_zero; // op updates zero
	logic set_carry; // op updates carry

	modport phase_src (output phase, cycle_end);
	modport alu (input op, acc, mem, bit_idx, carry_in,
		output result, carry_out, zero, to_mem, to_acc, set_zero, set_carry);
	modport seq (input phase, cycle_end, result, carry_out, zero, to_mem, to_acc,
		set_zero, set_carry, output op, acc, mem, bit_idx, carry_in);
endinterface : ics_core_if
`default_nettype wire

// *** core/ics_phase_gen.sv ***
`timescale 1ns/1ns
`default_nettype none
module ics_phase_gen (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	ics_core_if.phase_src core
);
	// ----------------------------------------------------------------
	// phase state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ics_pkg::PHASE_W-1:0] phase; // clock within the cycle
		logic cycle_end; // registered so the boundary is glitch free
	} ics_phase_t;

	ics_phase_t s;
	ics_phase_t next_s;

	// four clocks per cycle, wrap at the last phase
	always_comb begin
		next_s = s;
		if (s.phase == ics_pkg::PHASE_LAST) begin
			next_s.phase = ics_pkg::PHASE_FIRST;
		end else begin
			next_s.phase = s.phase + ics_pkg::PHASE_STEP;
		end
		next_s.cycle_end = (next_s.phase == ics_pkg::PHASE_LAST);
	end

	// restart at the first phase out of reset
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			s <= '{phase: ics_pkg::PHASE_FIRST, cycle_end: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign core.phase = s.phase;
	assign core.cycle_end = s.cycle_end;
endmodule : ics_phase_gen
`default_nettype wire

// *** core/ics_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
module ics_alu (
	ics_core_if.alu core
);
	// ----------------------------------------------------------------
	// widened sums keep the ninth bit for carry and borrow
	// ----------------------------------------------------------------
	logic [8:0] sum; // acc plus operand
	logic [8:0] diff; // acc minus operand, bit 8 set on borrow
	logic [7:0] mask; // selected bit

	assign sum = {1'b0, core.acc} + {1'b0, core.mem};
	assign diff = {1'b0, core.acc} - {1'b0, core.mem};
	assign mask = 8'h01 << core.bit_idx;
	assign core.zero = (core.result == 8'h00);

	// ----------------------------------------------------------------
	// operation decode, no state here
	// ----------------------------------------------------------------
	always_comb begin
		core.result = core.acc;
		core.carry_out = core.carry_in;
		core.to_mem = 1'b0;
		core.to_acc = 1'b0;
		core.set_zero = 1'b0;
		core.set_carry = 1'b0;
		unique case (core.op)
			ics_pkg::move_mem_to_acc_op, ics_pkg::move_imm_to_acc_op: begin
				core.result = core.mem;
				core.to_acc = 1'b1;
			end
			ics_pkg::move_acc_to_mem_op: begin
				core.to_mem = 1'b1;
			end
			ics_pkg::add_mem_op, ics_pkg::add_imm_op: begin
				core.result = sum[7:0];
				core.carry_out = sum[8];
				{core.to_acc, core.set_zero, core.set_carry} = 3'h7;
			end
			ics_pkg::sub_mem_op, ics_pkg::sub_imm_op: begin
				core.result = diff[7:0];
				core.carry_out = ~diff[8];
				{core.to_acc, core.set_zero, core.set_carry} = 3'h7;
			end
			ics_pkg::and_mem_op: begin
				core.result = core.acc & core.mem;
				{core.to_acc, core.set_zero} = 2'h3;
			end
			ics_pkg::or_mem_op: begin
				core.result = core.acc | core.mem;
				{core.to_acc, core.set_zero} = 2'h3;
			end
			ics_pkg::xor_mem_op: begin
				core.result = core.acc ^ core.mem;
				{core.to_acc, core.set_zero} = 2'h3;
			end
			ics_pkg::complement_op: begin
				core.result = ~core.mem;
				{core.to_mem, core.set_zero} = 2'h3;
			end
			ics_pkg::increment_op, ics_pkg::increment_to_acc_op: begin
				core.result = core.mem + 8'h01;
				core.set_zero = 1'b1;
				core.to_mem = (core.op == ics_pkg::increment_op);
				core.to_acc = (core.op == ics_pkg::increment_to_acc_op);
			end
			ics_pkg::decrement_op, ics_pkg::decrement_to_acc_op: begin
				core.result = core.mem - 8'h01;
				core.set_zero = 1'b1;
				core.to_mem = (core.op == ics_pkg::decrement_op);
				core.to_acc = (core.op == ics_pkg::decrement_to_acc_op);
			end
			ics_pkg::rotate_right_op: begin
				core.result = {core.mem[0], core.mem[7:1]};
				core.to_mem = 1'b1;
			end
			ics_pkg::rotate_left_op: begin
				core.result = {core.mem[6:0], core.mem[7]};
				core.to_mem = 1'b1;
			end
			ics_pkg::rotate_right_carry_op: begin
				core.result = {core.carry_in, core.mem[7:1]};
				core.carry_out = core.mem[0];
				{core.to_mem, core.set_carry} = 2'h3;
			end
			ics_pkg::rotate_left_carry_op: begin
				core.result = {core.mem[6:0], core.carry_in};
				core.carry_out = core.mem[7];
				{core.to_mem, core.set_carry} = 2'h3;
			end
			ics_pkg::bit_set_op: begin
				core.result = core.mem | mask;
				core.to_mem = 1'b1;
			end
			ics_pkg::bit_clear_op: begin
				core.result = core.mem & ~mask;
				core.to_mem = 1'b1;
			end
			// control flow ops and illegal codes leave data alone
			default: begin
			end
		endcase
	end
endmodule : ics_alu
`default_nettype wire

// *** core/ics_sequencer.sv ***
// How it works
// - four system clocks make one instruction cycle
// - ordinary ops one cycle, taken branch/call/table two
// - jumps, calls, returns, program_counter_low writes add one
// - taken skip adds a cycle, untaken does not
// - logic ops set zero flag on zero
// - rotates shift one bit, carry variants via carry
// - increment and decrement change operand by one
// - add carry above 255, subtract borrow below 0
// - bit set/clear rewrite only bit i
// - return resumes right after the calling instruction
// - jump loads target, saves no return address
// - conditional branch tests byte or bit, maybe bypasses
// - moves between register, accumulator and immediate
// - table read fetches words from program memory
// - oscillator frequency fixed at 8, 12 or 16 MHz
// - plain data accesses reach sector 0 only
// - interrupt return also sets global interrupt enable
`timescale 1ns/1ns
`default_nettype none
module ics_sequencer #(
	parameter int STACK_DEPTH = 8 // return address levels
) (
	input wire logic ref_clk_in,
	input wire logic srst_in,
	input wire logic [15:0] instr_word_in,
	input wire logic [7:0] data_rd_in,
	input wire logic [1:0] rc_freq_cfg_in,
	input wire logic rc_freq_select_hi_in,
	input wire logic rc_freq_select_lo_in,
	output logic [ics_pkg::PC_W-1:0] prog_addr_out,
	output logic [ics_pkg::DADDR_W-1:0] data_addr_out,
	output logic data_wr_out,
	output logic [7:0] data_wdata_out,
	output logic [7:0] acc_out,
	output logic carry_out,
	output logic zero_out,
	output logic global_interrupt_enable_out,
	output logic [7:0] table_hi_out,
	output logic instr_done_out,
	output logic extra_cycle_out,
	output logic [1:0] rc_freq_code_out,
	output logic rc_accuracy_ok_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	localparam int SP_W = $clog2(STACK_DEPTH); // stack pointer width

	typedef struct packed {
		ics_pkg::ics_seq_t seq; // exec or extra cycle
		logic [ics_pkg::PC_W-1:0] pc; // address of the current instruction
		logic [ics_pkg::PC_W-1:0] fetch_addr; // address shown to program memory
		logic [ics_pkg::DADDR_W-1:0] daddr; // data memory address
		logic wr; // data write strobe
		logic [7:0] wdata; // data write byte
		logic [7:0] acc; // accumulator
		logic carry; // carry flag, low means borrow
		logic zero; // zero flag
		logic gie; // global_interrupt_enable
		logic [7:0] table_hi; // upper byte of the last table word
		logic tbl_pend; // extra cycle is a table fetch
		logic done; // instruction retired
		logic [SP_W-1:0] sp; // number of saved return addresses
		logic [STACK_DEPTH-1:0][ics_pkg::PC_W-1:0] stack; // return addresses
		logic [1:0] rc_code; // programmed oscillator choice
		logic rc_ok; // software select matches it
		logic cfg_taken; // programmed choice already latched
	} ics_seq_state_t;

	ics_seq_state_t s;
	ics_seq_state_t next_s;

	ics_core_if core ();

	// ----------------------------------------------------------------
	// sub-blocks
	// ----------------------------------------------------------------
	ics_phase_gen u_phase (
		.ref_clk_in(ref_clk_in),
		.srst_in(srst_in),
		.core(core)
	);

	ics_alu u_alu (
		.core(core)
	);

	// ----------------------------------------------------------------
	// instruction word fields
	// ----------------------------------------------------------------
	ics_pkg::ics_op_t op; // decoded operation
	logic [7:0] opnd; // data address or immediate
	logic [2:0] bidx; // bit index
	logic [ics_pkg::PC_W-1:0] tgt; // jump target
	logic skip_hit; // branch test says bypass
	logic boundary_exec; // last phase of an executing cycle

	// fields come straight off the fetched word, no decode register
	assign op = ics_pkg::ics_op_t'(instr_word_in[ics_pkg::OP_HI:ics_pkg::OP_LO]);
	assign opnd = instr_word_in[ics_pkg::OPND_HI:0];
	assign bidx = instr_word_in[ics_pkg::BIT_HI:ics_pkg::BIT_LO];
	assign tgt = instr_word_in[ics_pkg::TGT_HI:0];
	assign boundary_exec = core.cycle_end && (s.seq == ics_pkg::seq_exec);
	assign skip_hit = ((op == ics_pkg::skip_if_zero_op) && (data_rd_in == 8'h00))
		|| ((op == ics_pkg::skip_if_bit_set_op) && data_rd_in[bidx]);

	// immediates ride the operand path, so the alu sees one source
	assign core.op = op;
	assign core.acc = s.acc;
	assign core.mem = ics_pkg::is_imm(op) ? opnd : data_rd_in;
	assign core.bit_idx = bidx;
	assign core.carry_in = s.carry;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	// one process works out the whole next state
	always_comb begin
		next_s = s;
		next_s.wr = 1'b0;
		next_s.done = 1'b0;
		// oscillator choice caught once after reset release
		if (!s.cfg_taken) begin
			next_s.cfg_taken = 1'b1;
			next_s.rc_code = (rc_freq_cfg_in == ics_pkg::RC_BAD)
				? ics_pkg::RC_8MHZ : rc_freq_cfg_in;
		end
		next_s.rc_ok = ({rc_freq_select_hi_in, rc_freq_select_lo_in} == s.rc_code);
		// address the operand early so the byte settles by the boundary
		if ((core.phase == ics_pkg::PHASE_FIRST) && (s.seq == ics_pkg::seq_exec)) begin
			next_s.daddr = {ics_pkg::SECTOR0, opnd};
		end
		if (boundary_exec) begin
			next_s.pc = s.pc + ics_pkg::PC_STEP;
			if (core.to_acc) begin
				next_s.acc = core.result;
			end
			if (core.set_zero) begin
				next_s.zero = core.zero;
			end
			if (core.set_carry) begin
				next_s.carry = core.carry_out;
			end
			if (core.to_mem) begin
				next_s.wr = 1'b1;
				next_s.wdata = core.result;
				// a write to program_counter_low is a direct jump
				if (opnd == ics_pkg::PCL_ADDR) begin
					next_s.pc = {s.pc[ics_pkg::PC_W-1:8], core.result};
					next_s.seq = ics_pkg::seq_extra;
				end
			end
			// flow changes override the plain pc step above
			unique case (op)
				ics_pkg::unconditional_jump_op: begin
					next_s.pc = tgt;
					next_s.seq = ics_pkg::seq_extra;
				end
				ics_pkg::subroutine_call_op: begin
					// no full check: a ninth call overwrites the oldest entry
					next_s.stack[s.sp] = s.pc + ics_pkg::PC_STEP;
					next_s.sp = s.sp + SP_W'(1);
					next_s.pc = tgt;
					next_s.seq = ics_pkg::seq_extra;
				end
				ics_pkg::subroutine_return_op, ics_pkg::interrupt_return_op: begin
					// an empty stack hands back whatever the wrapped slot holds
					next_s.pc = s.stack[s.sp - SP_W'(1)];
					next_s.sp = s.sp - SP_W'(1);
					next_s.seq = ics_pkg::seq_extra;
					if (op == ics_pkg::interrupt_return_op) begin
						next_s.gie = 1'b1;
					end
				end
				ics_pkg::skip_if_zero_op, ics_pkg::skip_if_bit_set_op: begin
					if (skip_hit) begin
						next_s.pc = s.pc + ics_pkg::SKIP_STEP;
						next_s.seq = ics_pkg::seq_extra;
					end
				end
				ics_pkg::table_read_op: begin
					next_s.tbl_pend = 1'b1;
					next_s.seq = ics_pkg::seq_extra;
				end
				// other codes, legal or not, need no flow change
				default: begin
				end
			endcase
			// the extra cycle of a table read fetches the table word
			next_s.fetch_addr = next_s.tbl_pend ? {ics_pkg::TABLE_PAGE, opnd} : next_s.pc;
			next_s.done = (next_s.seq == ics_pkg::seq_exec);
		end else if (core.cycle_end) begin
			// second cycle over: finish a table read, resume fetching
			if (s.tbl_pend) begin
				next_s.acc = instr_word_in[ics_pkg::OPND_HI:0];
				next_s.table_hi = instr_word_in[ics_pkg::OP_HI:ics_pkg::TBL_HI_LO];
				next_s.tbl_pend = 1'b0;
			end
			next_s.seq = ics_pkg::seq_exec;
			next_s.fetch_addr = s.pc;
			next_s.done = 1'b1;
		end
	end

	// all-zero reset: exec state, address zero, no write pending
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from state
	// ----------------------------------------------------------------
	// no logic between state and pins keeps output timing flat
	assign prog_addr_out = s.fetch_addr;
	assign data_addr_out = s.daddr;
	assign data_wr_out = s.wr;
	assign data_wdata_out = s.wdata;
	assign acc_out = s.acc;
	assign carry_out = s.carry;
	assign zero_out = s.zero;
	assign global_interrupt_enable_out = s.gie;
	assign table_hi_out = s.table_hi;
	assign instr_done_out = s.done;
	assign extra_cycle_out = (s.seq == ics_pkg::seq_extra);
	assign rc_freq_code_out = s.rc_code;
	assign rc_accuracy_ok_out = s.rc_ok;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (srst_in);

	// three quiet clocks, then the next boundary
	sequence seq_rest_of_cycle;
		!core.cycle_end [*3] ##1 core.cycle_end;
	endsequence

	// four clocks flagged as extra, then the retire pulse
	sequence seq_extra_cycle;
		(extra_cycle_out && !instr_done_out) [*4] ##1 (instr_done_out && !extra_cycle_out);
	endsequence

	// ----------------------------------------------------------------
	// cycle timing checks
	// ----------------------------------------------------------------
	a_cycle_four_phases: assert property (
		core.cycle_end |=> seq_rest_of_cycle) else $error("cycle not four clocks");
	a_reset_start: assert property (
		$past(srst_in) |-> (core.phase == ics_pkg::PHASE_FIRST) && !instr_done_out)
		else $error("bad state after reset");
	a_jump_two_cycles: assert property (
		boundary_exec && (op == ics_pkg::unconditional_jump_op)
		|=> (s.pc == $past(tgt)) && ($past(s.sp) == s.sp) ##0 seq_extra_cycle)
		else $error("jump timing wrong");
	a_single_cycle: assert property (
		boundary_exec && (op == ics_pkg::add_mem_op) |=> instr_done_out && !extra_cycle_out)
		else $error("ordinary op took extra cycle");
	a_skip_taken: assert property (
		boundary_exec && skip_hit
		|=> (s.pc == $past(s.pc) + ics_pkg::SKIP_STEP) ##0 seq_extra_cycle)
		else $error("taken skip wrong");
	// ----------------------------------------------------------------
	// data path checks
	// ----------------------------------------------------------------
	a_logic_zero: assert property (
		boundary_exec && (op == ics_pkg::and_mem_op)
		|=> zero_out == (($past(s.acc) & $past(data_rd_in)) == 8'h00))
		else $error("zero flag wrong");
	a_rotate_carry: assert property (
		boundary_exec && (op == ics_pkg::rotate_left_carry_op)
		|=> (carry_out == $past(data_rd_in[7])) && data_wr_out)
		else $error("rotate carry wrong");
	a_inc_by_one: assert property (
		boundary_exec && (op == ics_pkg::increment_op)
		|=> data_wr_out && (data_wdata_out == $past(data_rd_in) + 8'h01))
		else $error("increment wrong");
	a_add_carry: assert property (
		boundary_exec && (op == ics_pkg::add_mem_op)
		|=> carry_out == ((int'($past(s.acc)) + int'($past(data_rd_in))) > ics_pkg::BYTE_MAX))
		else $error("add carry wrong");
	a_bit_clear: assert property (
		boundary_exec && (op == ics_pkg::bit_clear_op)
		|=> data_wr_out && (data_wdata_out == ($past(data_rd_in) & ~(8'h01 << $past(bidx)))))
		else $error("bit clear touched other bits");
	// ----------------------------------------------------------------
	// control flow and address checks
	// ----------------------------------------------------------------
	a_call_return: assert property (
		boundary_exec && (op == ics_pkg::subroutine_call_op)
		|=> s.stack[$past(s.sp)] == $past(s.pc) + ics_pkg::PC_STEP)
		else $error("return address wrong");
	a_interrupt_return_op_gie: assert property (
		boundary_exec && (op == ics_pkg::interrupt_return_op) |=> global_interrupt_enable_out)
		else $error("interrupt return left enable low");
	a_sector_zero: assert property (
		data_addr_out[ics_pkg::DADDR_W-1:8] == ics_pkg::SECTOR0)
		else $error("access left sector 0");
endmodule : ics_sequencer
`default_nettype wire

// *** tb/ics_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ------------------------------
// program and data memory model
// ------------------------------
module ics_mem_model (
	input wire logic ref_clk_in,
	input wire logic [ics_pkg::PC_W-1:0] prog_addr_in,
	input wire logic [ics_pkg::DADDR_W-1:0] data_addr_in,
	input wire logic data_wr_in,
	input wire logic [7:0] data_wdata_in,
	output logic [15:0] instr_word_out,
	output logic [7:0] data_rd_out
);
	logic [15:0] pmem [0:2047]; // words, filled by the bench
	logic [7:0] dmem [0:511]; // data bytes, both sectors
	// combinational fetch, tables live in the same array
	assign instr_word_out = pmem[prog_addr_in];
	assign data_rd_out = dmem[data_addr_in];
	// one-clock strobe, so one write per pulse
	always_ff @(posedge ref_clk_in) begin
		if (data_wr_in) begin
			dmem[data_addr_in] <= data_wdata_in;
		end
	end
endmodule : ics_mem_model
`default_nettype wire

// *** tb/instruction_cycle_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module instruction_cycle_sequencer_tb;
	logic ref_clk_in = 1'b0; // 50 MHz
	logic srst_in = 1'b1; // held from time zero
	logic [1:0] cfg = 2'h0; // programmed frequency option
	logic sel_hi = 1'b0, sel_lo = 1'b0; // software select bits
	logic [15:0] iw;
	logic [7:0] drd, wd, acc, thi;
	logic [10:0] pa;
	logic [8:0] da;
	logic wr, carry, zero, gie, done, xc, ok;
	logic [1:0] code;
	int fails = 0, num_checks = 0;
	ics_sequencer i_dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .instr_word_in(iw),
		.data_rd_in(drd), .rc_freq_cfg_in(cfg), .rc_freq_select_hi_in(sel_hi),
		.rc_freq_select_lo_in(sel_lo), .prog_addr_out(pa), .data_addr_out(da),
		.data_wr_out(wr), .data_wdata_out(wd), .acc_out(acc), .carry_out(carry),
		.zero_out(zero), .global_interrupt_enable_out(gie), .table_hi_out(thi),
		.instr_done_out(done), .extra_cycle_out(xc), .rc_freq_code_out(code),
		.rc_accuracy_ok_out(ok));
	ics_mem_model i_mem (.ref_clk_in(ref_clk_in), .prog_addr_in(pa), .data_addr_in(da),
		.data_wr_in(wr), .data_wdata_in(wd), .instr_word_out(iw), .data_rd_out(drd));
	initial forever #10 ref_clk_in = ~ref_clk_in;
	// ------------------------------
	// helpers
	// ------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [15:0] w(input ics_pkg::ics_op_t op, input logic [10:0] arg);
		w = {op, arg};
	endfunction : w
	// eight held clocks, then acc and the low fetch address must read zero
	task restart;
		srst_in = 1'b1;
		repeat (8) @(negedge ref_clk_in);
		chk({acc, pa[7:0]}, 16'h0000);
		srst_in = 1'b0;
	endtask : restart
	// clocks until the next retire pulse, bounded
	task step(input int exp_cyc);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_in);
			n++;
		end while (done !== 1'b1 && n < 20);
		chk(16'(n), 16'(exp_cyc));
	endtask : step
	// ------------------------------
	// scenarios
	// ------------------------------
	task t_rc;
		logic [1:0] e;
		for (int c = 0; c < 4; c++) begin
			e = (c == 3) ? 2'h0 : 2'(c); // unprogrammed code falls back to 8 MHz
			cfg = 2'(c);
			{sel_hi, sel_lo} = e;
			restart;
			repeat (3) @(negedge ref_clk_in);
			chk(16'(code), 16'(e));
			chk(16'(ok), 16'h0001);
			{sel_hi, sel_lo} = ~e;
			repeat (2) @(negedge ref_clk_in);
			chk(16'(ok), 16'h0000);
		end
	endtask : t_rc
	task t_flow;
		i_mem.pmem[1] = w(ics_pkg::unconditional_jump_op, 11'h004);
		i_mem.pmem[4] = w(ics_pkg::subroutine_call_op, 11'h00c);
		i_mem.pmem[12] = w(ics_pkg::subroutine_return_op, 11'h000);
		i_mem.pmem[5] = w(ics_pkg::skip_if_bit_set_op, 11'h221);
		i_mem.pmem[7] = w(ics_pkg::skip_if_zero_op, 11'h021);
		i_mem.pmem[8] = w(ics_pkg::table_read_op, 11'h030);
		i_mem.pmem[9] = w(ics_pkg::move_acc_to_mem_op, 11'h007);
		i_mem.pmem[11'h730] = 16'h5a14;
		i_mem.pmem[11'h014] = w(ics_pkg::interrupt_return_op, 11'h000);
		i_mem.dmem[9'h021] = 8'h05;
		restart;
		step(4);
		step(8);
		chk(16'(pa), 16'h0004);
		step(8);
		chk(16'(pa), 16'h000c);
		step(8);
		chk({gie, 4'h0, pa}, 16'h0005);
		step(8);
		chk(16'(pa), 16'h0007);
		step(4);
		chk(16'(pa), 16'h0008);
		// look inside the second cycle of the table read
		repeat (4) @(negedge ref_clk_in);
		chk(16'(xc), 16'h0001);
		step(4);
		chk({thi, acc}, 16'h5a14);
		step(8);
		chk(16'(pa), 16'h0014);
		step(8);
		chk(16'(gie), 16'h0001);
	endtask : t_flow
	task t_alu;
		i_mem.pmem[0] = w(ics_pkg::move_imm_to_acc_op, 11'h0f0);
		i_mem.pmem[1] = w(ics_pkg::add_mem_op, 11'h047);
		i_mem.pmem[2] = w(ics_pkg::sub_imm_op, 11'h011);
		i_mem.pmem[3] = w(ics_pkg::and_mem_op, 11'h040);
		i_mem.pmem[4] = w(ics_pkg::or_mem_op, 11'h041);
		i_mem.pmem[5] = w(ics_pkg::rotate_left_carry_op, 11'h042);
		i_mem.pmem[6] = w(ics_pkg::increment_to_acc_op, 11'h043);
		i_mem.pmem[7] = w(ics_pkg::bit_clear_op, 11'h344);
		i_mem.pmem[8] = w(ics_pkg::bit_set_op, 11'h045);
		i_mem.pmem[9] = w(ics_pkg::decrement_op, 11'h046);
		i_mem.pmem[10] = w(ics_pkg::move_mem_to_acc_op, 11'h046);
		i_mem.pmem[11] = w(ics_pkg::increment_op, 11'h046);
		i_mem.dmem[9'h041] = 8'h3c;
		i_mem.dmem[9'h042] = 8'h81;
		i_mem.dmem[9'h043] = 8'hff;
		i_mem.dmem[9'h044] = 8'hff;
		i_mem.dmem[9'h047] = 8'h20;
		restart;
		step(4);
		chk(16'(acc), 16'h00f0);
		step(4);
		chk(16'({carry, acc}), 16'h0110);
		step(4);
		chk(16'({carry, acc}), 16'h00ff);
		step(4);
		chk(16'({zero, acc}), 16'h0100);
		step(4);
		chk(16'({zero, acc}), 16'h003c);
		step(4);
		chk(16'(carry), 16'h0001);
		step(4);
		chk(16'({zero, acc}), 16'h0100);
		repeat (3) step(4);
		step(4);
		chk({acc, da[7:0]}, 16'hff46);
		chk(16'(da), 16'h0046);
		step(4);
		chk(16'(zero), 16'h0001);
		chk({i_mem.dmem[9'h044], i_mem.dmem[9'h045]}, 16'hf701);
		chk(16'(i_mem.dmem[9'h042]), 16'h0002);
	endtask : t_alu
	// ------------------------------
	// run and verdict
	// ------------------------------
	task conclude;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// whole run is under two hundred clocks, so this only cuts a hang
	initial begin
		repeat (20000) @(posedge ref_clk_in);
		fails++;
		conclude;
	end
	initial begin
		for (int i = 0; i < 2048; i++) i_mem.pmem[i] = 16'h0000;
		for (int i = 0; i < 512; i++) i_mem.dmem[i] = 8'h00;
		t_rc;
		t_flow;
		t_alu;
		conclude;
	end
endmodule : instruction_cycle_sequencer_tb
`default_nettype wire
